// >>> rtl/stop_wake_seq.v
// stop-state entry and interrupt wake sequencer with its control registers
// assumes pin inputs are asynchronous; prescaler ticks and cpu strobes come from core_clk logic
`timescale 1ns/1ps
`include "stop_wake_regs.vh"

module stop_wake_seq (
  // clock and resets
  input wire core_clk,
  input wire reset_n,
  input wire por_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // cpu side
  input wire stop_instruction,
  // wake requests: pins 3-7, timers a0 a1 a2 a4 a9, b0-b2, uart0/1 tx rx
  input wire [4:0] external_irq_pin,
  input wire [4:0] irq_pin_edge_mode,
  input wire [4:0] timer_a_irq,
  input wire [4:0] timer_a_event_mode,
  input wire [2:0] timer_b_irq,
  input wire [3:0] uart_irq,
  input wire [3:0] uart_ext_clk,
  input wire [16:0] wake_enable,
  // clock generator ticks
  input wire xin_tick,
  input wire xin_div16_clock,
  input wire xin_div32_clock,
  input wire xin_div64_clock,
  input wire xin_div128_clock,
  input wire watchdog_div32_clock,
  input wire watchdog_div512_clock,
  // clock gating outputs
  output reg osc_enable,
  output reg pll_enable,
  output reg osc_output_pin,
  output reg system_clock_main_en,
  output reg peripheral_divided_clocks_en,
  output reg watchdog_clocks_en,
  output reg cpu_clock_en,
  output reg bus_interface_clock_en,
  output reg xin_accept_en,
  // interrupt hand-off
  output reg [16:0] held_irq,
  output reg irq_release,
  output reg stopped_flag
);

  localparam ST_RUN = 2'b00;
  localparam ST_STOP = 2'b01;
  localparam ST_STAB = 2'b10;
  localparam ST_DELAY = 2'b11;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg [4:0] pin_s1_r;
  reg [4:0] pin_s2_r;
  reg [4:0] pin_prev_r;
  always @(posedge core_clk) begin
    pin_s1_r <= external_irq_pin;
    pin_s2_r <= pin_s1_r;
    pin_prev_r <= pin_s2_r;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg wdt_fsel_r;
  reg [1:0] stop_src_r;
  reg stop_dis_r;
  reg ext_clk_r;
  reg key_ok_r;
  reg pll_en_r;
  reg pll_sel_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [11:0] wdt_cnt_r;
  reg [6:0] dly_cnt_r;
  reg wake_done_r;
  reg [16:0] wake_req;
  reg [16:0] level_mask;

  function [6:0] stop_delay;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: stop_delay = `DLY_SRC00;
        2'b01: stop_delay = `DLY_SRC01;
        2'b10: stop_delay = `DLY_SRC10;
        default: stop_delay = `DLY_SRC11;
      endcase
    end
  endfunction

  // qualifying request vector
  always @* begin
    wake_req = wake_enable & {uart_irq & uart_ext_clk, timer_b_irq,
      timer_a_irq & timer_a_event_mode,
      (irq_pin_edge_mode & ~pin_s2_r & pin_prev_r) | (~irq_pin_edge_mode & ~pin_s2_r)};
    level_mask = {12'h000, ~irq_pin_edge_mode};
  end

  wire any_wake = |wake_req; // first request wins
  wire use_wdt = ~ext_clk_r | pll_sel_r;
  wire wr_hit = reg_wr;
  wire stab_src = stop_src_r == 2'b00 ? xin_div32_clock :
                  stop_src_r == 2'b01 ? xin_div16_clock :
                  stop_src_r == 2'b10 ? xin_div128_clock : xin_div64_clock;
  wire norm_src = wdt_fsel_r ? watchdog_div32_clock : watchdog_div512_clock;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      wdt_fsel_r <= 1'b0;
      stop_src_r <= 2'b00;
      stop_dis_r <= 1'b0;
      ext_clk_r <= 1'b0;
      key_ok_r <= 1'b0;
      pll_en_r <= 1'b0;
      pll_sel_r <= 1'b0;
    end else if (wr_hit) begin
      key_ok_r <= 1'b0;
      case (reg_addr)
        `ADDR_WDT_FREQ: begin
          wdt_fsel_r <= reg_wdata[`BIT_WDT_FSEL];
          stop_src_r <= reg_wdata[`BIT_STOP_SRC_HI:`BIT_STOP_SRC_LO];
        end
        `ADDR_FUNC_SEL0: begin
          if (reg_wdata == `WRITE_KEY && !key_ok_r) begin
            key_ok_r <= 1'b1; // key alone changes nothing
          end else if (key_ok_r) begin
            stop_dis_r <= reg_wdata[`BIT_STOP_DIS];
            ext_clk_r <= reg_wdata[`BIT_EXT_CLK];
          end
        end
        `ADDR_CLK_CTRL: begin
          pll_en_r <= reg_wdata[`BIT_PLL_EN];
          pll_sel_r <= reg_wdata[`BIT_PLL_SEL];
        end
        default: begin
        end
      endcase
    end
  end

  // stop flag: power-on clears, other resets keep, write 0 clears, set wins
  wire stop_entry = state_r == ST_RUN && stop_instruction && !stop_dis_r;
  always @(posedge core_clk) begin
    if (!por_n) begin
      stopped_flag <= 1'b0;
    end else if (stop_entry) begin
      stopped_flag <= 1'b1;
    end else if (wr_hit && reg_addr == `ADDR_FUNC_SEL1 && !reg_wdata[`BIT_STOP_FLAG]) begin
      stopped_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_WDT_FREQ: reg_rdata <= {stop_src_r, 5'h00, wdt_fsel_r};
        `ADDR_FUNC_SEL0: reg_rdata <= {6'h00, ext_clk_r, stop_dis_r};
        `ADDR_FUNC_SEL1: reg_rdata <= {7'h00, stopped_flag};
        `ADDR_CLK_CTRL: reg_rdata <= {2'b00, pll_sel_r, 3'b000, pll_en_r, 1'b0};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // wake state machine
  // ----------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: if (stop_entry) state_nxt = ST_STOP;
      ST_STOP: if (any_wake) state_nxt = use_wdt ? ST_STAB : ST_DELAY;
      ST_STAB: if (!wdt_cnt_r[11]) state_nxt = ST_RUN;
      ST_DELAY: if (dly_cnt_r == 7'h00) state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= ST_RUN;
      wdt_cnt_r <= `WDT_LOAD;
      dly_cnt_r <= 7'h00;
      held_irq <= 17'h00000;
      irq_release <= 1'b0;
      wake_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wake_done_r <= 1'b0;
      // release follows the cpu clock start by one cycle
      irq_release <= wake_done_r;
      case (state_r)
        ST_RUN: begin
          wdt_cnt_r <= `WDT_LOAD;
          held_irq <= 17'h00000;
          if (norm_src && !stop_entry)
            wdt_cnt_r <= wdt_cnt_r; // normal watchdog counting lives elsewhere
        end
        ST_STOP: begin
          wdt_cnt_r <= `WDT_LOAD;
          dly_cnt_r <= stop_delay(stop_src_r); // full tick count
          held_irq <= wake_req & ~level_mask;
        end
        ST_STAB: begin
          if (stab_src)
            wdt_cnt_r <= wdt_cnt_r - 12'h001;
          held_irq <= held_irq | (wake_req & ~level_mask);
          if (!wdt_cnt_r[11])
            wake_done_r <= 1'b1;
        end
        ST_DELAY: begin
          if (xin_tick && dly_cnt_r != 7'h00)
            dly_cnt_r <= dly_cnt_r - 7'h01;
          held_irq <= held_irq | (wake_req & ~level_mask);
          if (dly_cnt_r == 7'h00)
            wake_done_r <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // clock enables
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      osc_output_pin <= 1'b0;
      system_clock_main_en <= 1'b1;
      peripheral_divided_clocks_en <= 1'b1;
      watchdog_clocks_en <= 1'b1;
      cpu_clock_en <= 1'b1;
      bus_interface_clock_en <= 1'b1;
      xin_accept_en <= 1'b1;
    end else begin
      osc_enable <= state_nxt != ST_STOP && !ext_clk_r;
      pll_enable <= state_nxt != ST_STOP && pll_en_r;
      osc_output_pin <= ext_clk_r; // held high with external clock
      system_clock_main_en <= state_nxt != ST_STOP;
      peripheral_divided_clocks_en <= state_nxt != ST_STOP;
      watchdog_clocks_en <= state_nxt != ST_STOP;
      cpu_clock_en <= state_nxt == ST_RUN;
      bus_interface_clock_en <= state_nxt == ST_RUN;
      xin_accept_en <= state_nxt != ST_STOP;
    end
  end

endmodule

// >>> rtl/stop_wake_regs.vh
// register offsets, field positions, reset values and timing counts for the stop/wake sequencer
// assumes a byte-wide register port clocked by core_clk at 200 MHz
//
// Behaviour
// - stop instruction halts the oscillator and PLL, entering the stop state.
// - while stopped, CPU, divided peripheral and watchdog prescaled clocks stop.
// - stop ends only on a qualifying interrupt request or hardware reset.
// - watchdog interval skipped only with external clock 1 and PLL select 0.
// - crystal in use or PLL selected: watchdog counter times the stabilisation.
// - watchdog wake restarts oscillator, PLL if enabled, and system clocks together.
// - stabilisation counts the source chosen by the stop-termination bits.
// - watchdog counter is loaded with all ones before stabilisation counting.
// - counter top bit falling starts CPU and bus clocks, no watchdog interrupt.
// - then the watchdog source reverts to the normal div32/div512 choice.
// - once CPU clocks run, the waking interrupt request is accepted.
// - wake sources are pins 3-7, chosen timers, serial ports in stated modes.
// - with several wake sources enabled, the first request ends stop.
// - requests during the wake interval are held, accepted after top bit falls.
// - level-sensed pin interrupts are not latched during the wake interval.
// - non-watchdog wake accepts the input clock and restarts system clocks.
// - non-watchdog delay: 00 gives 19, 01 11, 10 67, 11 35 input cycles.
// - external clock select disables the oscillator driver, holds output pin high.
// - protected register bits update only on the write right after key 55h.
// - stop entry sets a status flag; power-on clears, other resets keep, write 0 clears.
`ifndef STOP_WAKE_REGS_VH
`define STOP_WAKE_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_WDT_FREQ 8'h61
`define ADDR_FUNC_SEL0 8'h62
`define ADDR_FUNC_SEL1 8'h63
`define ADDR_CLK_CTRL 8'hBC

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_WDT_FSEL 0
`define BIT_STOP_SRC_LO 6
`define BIT_STOP_SRC_HI 7
`define BIT_STOP_DIS 0
`define BIT_EXT_CLK 1
`define BIT_STOP_FLAG 0
`define BIT_PLL_EN 1
`define BIT_PLL_SEL 5

// ----------------------------------------------------------------------
// values and timing counts
// ----------------------------------------------------------------------
`define WRITE_KEY 8'h55
`define WDT_LOAD 12'hFFF
`define DLY_SRC00 7'h13
`define DLY_SRC01 7'h0B
`define DLY_SRC10 7'h43
`define DLY_SRC11 7'h23

`endif

// >>> sim/clk_gen_model.sv
// clock generator stand-in: input-clock and prescaler ticks for the sequencer
// assumes one-cycle tick enables in the core_clk domain
`timescale 1ns/1ps
module clk_gen_model (
  // clock
  input logic core_clk,
  // supply state from the sequencer
  input logic system_clock_main_en,
  // ticks
  output logic xin_tick,
  output logic xin_div16_clock,
  output logic xin_div32_clock,
  output logic xin_div64_clock,
  output logic xin_div128_clock,
  output logic watchdog_div32_clock,
  output logic watchdog_div512_clock
);
  logic [5:0] c = 6'h00;
  wire run = system_clock_main_en === 1'b1;
  always @(posedge core_clk) begin
    c <= (c == 6'h3B) ? 6'h00 : c + 6'h01;
  end
  // external clock keeps arriving while stopped
  assign xin_tick = c % 3 == 0;
  // prescaled ticks die with the gated supplies; short periods keep runs brief
  assign xin_div16_clock = run && c % 2 == 0;
  assign xin_div32_clock = run && c % 3 == 1;
  assign xin_div64_clock = run && c % 4 == 1;
  assign xin_div128_clock = run && c % 5 == 2;
  assign watchdog_div32_clock = run && c % 6 == 3;
  assign watchdog_div512_clock = run && c % 7 == 3;
endmodule

// >>> sim/stop_wake_seq_sva.sv
// timing checks on the stop/wake sequencer ports
// assumes binding into stop_wake_seq
`timescale 1ns/1ps
module stop_wake_seq_sva (
  input logic core_clk,
  input logic reset_n,
  input logic stop_instruction,
  input logic cpu_clock_en,
  input logic bus_interface_clock_en,
  input logic system_clock_main_en,
  input logic peripheral_divided_clocks_en,
  input logic watchdog_clocks_en,
  input logic osc_enable,
  input logic pll_enable,
  input logic stopped_flag,
  input logic irq_release,
  input logic [16:0] wake_enable,
  input logic [4:0] timer_a_irq,
  input logic [4:0] timer_a_event_mode,
  input logic [2:0] timer_b_irq,
  input logic [3:0] uart_irq,
  input logic [3:0] uart_ext_clk
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire [11:0] src = {uart_irq & uart_ext_clk, timer_b_irq, timer_a_irq & timer_a_event_mode};
  stop_entry_a: assert property ($fell(cpu_clock_en) |-> $past(stop_instruction))
    else $error("cpu clock stopped without a stop request");
  osc_halt_a: assert property ($fell(cpu_clock_en) |-> !osc_enable && !pll_enable)
    else $error("oscillator or pll left running in stop");
  stop_gates_a: assert property (!system_clock_main_en |->
    !cpu_clock_en && !peripheral_divided_clocks_en && !watchdog_clocks_en)
    else $error("clock group running while stopped");
  cpu_bus_pair_a: assert property (cpu_clock_en == bus_interface_clock_en)
    else $error("cpu and bus clock enables differ");
  wake_cause_a: assert property ($rose(system_clock_main_en) |->
    $past(|(wake_enable[16:5] & src))) else $error("wake without request");
  staged_start_a: assert property ($rose(cpu_clock_en) |-> $past(system_clock_main_en, 2))
    else $error("cpu clock started with system clock");
  accept_after_a: assert property ($rose(cpu_clock_en) |=> irq_release ##1 !irq_release)
    else $error("wake request not released once");
  flag_on_stop_a: assert property ($fell(cpu_clock_en) |-> ##[0:1] stopped_flag)
    else $error("stop flag not set");
endmodule
bind stop_wake_seq stop_wake_seq_sva i_stop_wake_seq_sva (.*);

// >>> sim/stop_wake_seq_test.sv
// self-checking bench for the stop/wake sequencer
// assumes clk_gen_model supplies every tick input
`timescale 1ns/1ps
module stop_wake_seq_test;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic core_clk = 0;
  logic reset_n = 0;
  logic por_n = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic stop_instruction = 0;
  logic [11:0] irq_v = 12'h000;
  logic [4:0] external_irq_pin = 5'h1F;
  logic [4:0] irq_pin_edge_mode = 5'h00;
  logic [4:0] timer_a_event_mode = 5'h1F;
  logic [3:0] uart_ext_clk = 4'hF;
  logic [16:0] wake_enable = 17'h1FFFF;
  wire [4:0] timer_a_irq;
  wire [2:0] timer_b_irq;
  wire [3:0] uart_irq;
  wire [7:0] reg_rdata;
  wire [16:0] held_irq;
  wire xin_tick, xin_div16_clock, xin_div32_clock, xin_div64_clock, xin_div128_clock;
  wire watchdog_div32_clock, watchdog_div512_clock, osc_enable, pll_enable, osc_output_pin;
  wire system_clock_main_en, peripheral_divided_clocks_en, watchdog_clocks_en, cpu_clock_en;
  wire bus_interface_clock_en, xin_accept_en, irq_release, stopped_flag;
  wire [4:0] tk = {xin_div128_clock, xin_div64_clock, xin_div32_clock, xin_div16_clock, xin_tick};
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int dly[4] = '{19, 11, 67, 35};
  int wsel[4] = '{2, 1, 4, 3};
  assign {uart_irq, timer_b_irq, timer_a_irq} = irq_v;
  always #2.5 core_clk = ~core_clk;
  stop_wake_seq i_stop_wake_seq (.*);
  clk_gen_model i_clk_gen_model (.*);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic rst(input logic p);
    @(posedge core_clk);
    reset_n <= 1'b0;
    por_n <= p;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic pulse_stop();
    @(posedge core_clk);
    stop_instruction <= 1'b1;
    @(posedge core_clk);
    stop_instruction <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic wake(input int n, input int sel, input logic pll);
    int cnt;
    cnt = 0;
    pulse_stop();
    chk({cpu_clock_en, system_clock_main_en, stopped_flag}, 3'h1);
    @(posedge core_clk);
    irq_v <= 12'h001 << ($urandom % 12);
    for (int i = 0; i < 16000 && cpu_clock_en !== 1'b1; i++) begin
      @(negedge core_clk);
      if (i == 1) chk(system_clock_main_en, 1'b1);
      if (system_clock_main_en === 1'b1 && cpu_clock_en !== 1'b1) cnt += tk[sel];
    end
    chk(cnt, n);
    @(negedge core_clk);
    chk({irq_release, pll_enable}, {1'b1, pll});
    @(posedge core_clk);
    irq_v <= 12'h000;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h8D39B083));
    rst(1'b0);
    @(negedge core_clk);
    chk({osc_output_pin, pll_enable, cpu_clock_en, system_clock_main_en}, 4'h3);
    rdchk(8'h63, 8'h00);
    rdchk(8'h70, 8'h00);
    $display("reset test done");
    wr(8'h62, 8'h03);
    rdchk(8'h62, 8'h00);
    wr(8'h62, 8'h55);
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h03);
    rdchk(8'h62, 8'h00);
    wr(8'h62, 8'h55);
    wr(8'h62, 8'h03);
    rdchk(8'h62, 8'h03);
    chk(osc_output_pin, 1'b1);
    pulse_stop();
    chk(cpu_clock_en, 1'b1);
    wr(8'h62, 8'h55);
    wr(8'h62, 8'h02);
    $display("keyed write test done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h61, s << 6);
      wake(dly[s], 0, 1'b0);
    end
    rst(1'b1);
    rdchk(8'h63, 8'h01);
    wr(8'h63, 8'h00);
    rdchk(8'h63, 8'h00);
    $display("delay wake test done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h61, (s << 6) | 1);
      wake(2048, wsel[s], 1'b0);
    end
    wr(8'h62, 8'h55);
    wr(8'h62, 8'h02);
    wr(8'hBC, 8'h22);
    wr(8'h61, 8'h40);
    wake(2048, 1, 1'b1);
    rst(1'b0);
    rdchk(8'h63, 8'h00);
    $display("watchdog wake test done");
    tally_and_finish();
  end
endmodule
